// [logic/buck_sequencer.sv]
// How it works
// - First enable from shutdown waits the wake-up delay, then starts that converter.
// - With any converter active, a newly enabled one starts at once.
// - Power good rises once the output reaches the upper good threshold.
// - Power good falls when the output drops below the lower threshold.
// - Every power-good low lasts at least the hold time.
// - Enable low drops power good and stops the converter at once.
// - Discharge pull-down is on only while that enable is low.
// - All enables low returns to shutdown; next enable waits again.
// - Forced PWM: a minimum pulse every switching cycle.
// - High-side turn-ons of the four converters are phase staggered.
// - Level select low picks converter 3's low target, high the high.
// - Thermal trip drops all power good, then stops converters after lead time.
// - After thermal recovery, wait the safety delay before restart.
// - Thermal restart runs converters 1 to 4 with fixed spacing.
// - Input under-voltage drops all power good at once.
// - Under-voltage lasting the qualification time stops all converters.
// - Medium under-voltage: power good returns after hold and settled output.
// - Short under-voltage keeps converters running, power good held full time.
// - After under-voltage shutdown, restart 1 to 4 with fixed spacing.
// - Over-voltage drops power good; lasting qualification time stops converters.
// - Over-voltage restart below recovery level, 1 to 4 with fixed spacing.
// - Medium over-voltage: power good returns after hold and settled output.
// - Short over-voltage keeps converters running, power good held full time.
`include "buck_seq_map.svh"

module buck_sequencer #(
  parameter int WAKE_CYC       = `WAKE_CYC,
  parameter int HOLD_CYC       = `PG_HOLD_CYC,
  parameter int QUAL_CYC       = `QUAL_CYC,
  parameter int THERM_SAFE_CYC = `THERM_SAFE_CYC,
  parameter int STEP_CYC       = `STEP_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [3:0] converter_enable,
  input  wire logic [3:0] feedback_hi,
  input  wire logic [3:0] feedback_lo,
  input  wire logic       out3_level_select,
  input  wire logic       thermal_trip,
  input  wire logic       input_low_lockout,
  input  wire logic       input_high_guard,
  output logic      [3:0] converter_on,
  output logic      [3:0] switch_pulse,
  output logic      [3:0] discharge_on,
  output logic      [3:0] power_good_out,
  output logic            out3_level
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NS = 15;
  logic [NS-1:0] sync_a;
  logic [NS-1:0] sync_b;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {converter_enable, feedback_hi, feedback_lo, out3_level_select,
                 thermal_trip, input_low_lockout};
      sync_b <= sync_a;
    end
  end
  logic ovp_a;
  logic ovp_s;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovp_a <= 1'b0;
      ovp_s <= 1'b0;
    end else begin
      ovp_a <= input_high_guard;
      ovp_s <= ovp_a;
    end
  end
  wire [3:0] en_s  = sync_b[14:11];
  wire [3:0] fhi_s = sync_b[10:7];
  wire [3:0] flo_s = sync_b[6:3];
  wire       sel_s = sync_b[2];
  wire       tsd_s = sync_b[1];
  wire       uv_s  = sync_b[0];
  // Supply faults are handled alike; the thermal path has its own restart safety delay
  wire       sup_s = uv_s || ovp_s;

  // ----------------------------------------
  // Wake-up sequencing
  // ----------------------------------------
  buck_seq_pkg::seq_state_e seq;
  buck_seq_pkg::seq_state_e next_seq;
  logic [$clog2(WAKE_CYC+1)-1:0] wake_cnt;
  wire any_en   = |en_s;
  wire wake_end = (wake_cnt == '0);

  always_comb begin
    next_seq = seq;
    unique case (seq)
      buck_seq_pkg::SEQ_OFF:  if (any_en) next_seq = buck_seq_pkg::SEQ_WAKE;
      buck_seq_pkg::SEQ_WAKE: if (!any_en) next_seq = buck_seq_pkg::SEQ_OFF;
                              else if (wake_end) next_seq = buck_seq_pkg::SEQ_RUN;
      buck_seq_pkg::SEQ_RUN:  if (!any_en) next_seq = buck_seq_pkg::SEQ_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seq      <= buck_seq_pkg::SEQ_OFF;
      wake_cnt <= $bits(wake_cnt)'(WAKE_CYC);
    end else begin
      seq <= next_seq;
      if (seq != buck_seq_pkg::SEQ_WAKE) wake_cnt <= $bits(wake_cnt)'(WAKE_CYC);
      else if (!wake_end) wake_cnt <= wake_cnt - 1'b1;
    end
  end

  // ----------------------------------------
  // Fault handling
  // ----------------------------------------
  buck_seq_pkg::fault_state_e flt;
  buck_seq_pkg::fault_state_e next_flt;
  localparam int FW = $clog2(THERM_SAFE_CYC + 1);
  logic [FW-1:0] flt_cnt;
  logic [1:0]    step_idx;
  logic          by_therm;
  wire fault_now = tsd_s || sup_s;
  wire cnt_zero  = (flt_cnt == '0);
  wire last_step = (step_idx == 2'd3);

  always_comb begin
    next_flt = flt;
    unique case (flt)
      buck_seq_pkg::FLT_NONE:    if (fault_now) next_flt = buck_seq_pkg::FLT_WARN;
      // Short supply faults end here with converters left running
      buck_seq_pkg::FLT_WARN:    if (!fault_now)
                                   next_flt = buck_seq_pkg::FLT_NONE;
                                 else if (cnt_zero) next_flt = buck_seq_pkg::FLT_DOWN;
      buck_seq_pkg::FLT_DOWN:    if (!fault_now && cnt_zero)
                                   next_flt = buck_seq_pkg::FLT_RESTART;
      buck_seq_pkg::FLT_RESTART: if (fault_now) next_flt = buck_seq_pkg::FLT_DOWN;
                                 else if (last_step && cnt_zero)
                                   next_flt = buck_seq_pkg::FLT_NONE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flt      <= buck_seq_pkg::FLT_NONE;
      flt_cnt  <= '0;
      step_idx <= '0;
      by_therm <= 1'b0;
    end else begin
      flt <= next_flt;
      unique case (next_flt)
        buck_seq_pkg::FLT_NONE: begin
          flt_cnt  <= FW'(QUAL_CYC);
          step_idx <= '0;
        end
        buck_seq_pkg::FLT_WARN: begin
          if (flt == buck_seq_pkg::FLT_NONE) begin
            flt_cnt <= FW'(QUAL_CYC - 1);
          end else begin
            flt_cnt <= flt_cnt - 1'b1;
          end
          by_therm <= tsd_s;
        end
        buck_seq_pkg::FLT_DOWN: begin
          step_idx <= '0;
          if (tsd_s) by_therm <= 1'b1;
          if (fault_now) flt_cnt <= by_therm || tsd_s ? FW'(THERM_SAFE_CYC) : '0;
          else if (!cnt_zero) flt_cnt <= flt_cnt - 1'b1;
        end
        buck_seq_pkg::FLT_RESTART: begin
          if (flt != buck_seq_pkg::FLT_RESTART || cnt_zero) begin
            flt_cnt <= FW'(STEP_CYC - 1);
            if (flt == buck_seq_pkg::FLT_RESTART) begin
              step_idx <= step_idx + 1'b1;
            end
          end else begin
            flt_cnt <= flt_cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // Quiet time since the last fault cycle, saturating at the safety delay
  logic [FW-1:0] calm_cnt;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      calm_cnt <= '0;
    end else if (fault_now) begin
      calm_cnt <= '0;
    end else if (calm_cnt != FW'(THERM_SAFE_CYC)) begin
      calm_cnt <= calm_cnt + 1'b1;
    end
  end

  // Converters let back on during ordered restart: 1 then 2 then 3 then 4
  wire [3:0] restart_mask = (flt == buck_seq_pkg::FLT_DOWN) ? 4'h0 :
                            (flt == buck_seq_pkg::FLT_RESTART) ?
                              4'((5'h2 << step_idx) - 5'h1) : 4'hf;
  wire [3:0] pg_force     = ~en_s | {4{fault_now || flt != buck_seq_pkg::FLT_NONE}};

  // ----------------------------------------
  // Converter run, discharge and level
  // ----------------------------------------
  // Wake is skipped whenever a converter is already running
  wire       awake       = (seq == buck_seq_pkg::SEQ_RUN) || |converter_on;
  wire [3:0] next_on     = en_s & restart_mask & {4{awake || wake_end && any_en}};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      converter_on <= '0;
      discharge_on <= 4'hf;
      out3_level   <= `OUT3_LOW_CODE;
    end else begin
      converter_on <= next_on;
      discharge_on <= ~en_s;
      out3_level   <= sel_s ? `OUT3_HIGH_CODE : `OUT3_LOW_CODE;
    end
  end

  conv_ctrl_if cc ();
  assign cc.run = converter_on;
  phase_pwm #(.PERIOD(`SW_PERIOD)) u_pwm (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cc      (cc)
  );
  assign switch_pulse = cc.pwm_pulse;

  // ----------------------------------------
  // Power good per converter
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_CONV; g++) begin : g_pg
      pg_hold #(.HOLD_CYC(HOLD_CYC)) u_pg (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .force_low (pg_force[g] || !converter_on[g]),
        .above_hi  (fhi_s[g]),
        .below_lo  (!flo_s[g]),
        .pg        (power_good_out[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Hold-time watch
  // ----------------------------------------
  // Counted apart from the hold counter, so a broken reload still shows
  localparam int HW = $clog2(HOLD_CYC + 1);
  generate
    for (g = 0; g < `NUM_CONV; g++) begin : g_watch
      logic [HW-1:0] low_run;
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          low_run <= '0;
        end else if (power_good_out[g]) begin
          low_run <= '0;
        end else if (low_run != HW'(HOLD_CYC)) begin
          low_run <= low_run + 1'b1;
        end
      end
      a_hold_full : assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(power_good_out[g]) |-> low_run == HW'(HOLD_CYC))
        else $error("power good low shorter than hold time");
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_disch_follow : assert property (@(posedge clk_sys) disable iff (!rst_n)
    discharge_on == ~$past(en_s))
    else $error("discharge not tied to enable");
  a_off_no_dis : assert property (@(posedge clk_sys) disable iff (!rst_n)
    (converter_on & discharge_on) == 4'h0)
    else $error("converter on while discharging");
  a_fault_pg : assert property (@(posedge clk_sys) disable iff (!rst_n)
    fault_now |-> ##2 power_good_out == 4'h0)
    else $error("power good high during fault");
  a_down_off : assert property (@(posedge clk_sys) disable iff (!rst_n)
    flt == buck_seq_pkg::FLT_DOWN |=> converter_on == 4'h0)
    else $error("converter on during fault shutdown");
  a_order_one : assert property (@(posedge clk_sys) disable iff (!rst_n)
    flt == buck_seq_pkg::FLT_RESTART && step_idx == 2'd0 |=> !converter_on[1])
    else $error("restart order broken");
  a_level_sel : assert property (@(posedge clk_sys) disable iff (!rst_n)
    out3_level == $past(sel_s))
    else $error("converter 3 level wrong");
  a_off_state : assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq == buck_seq_pkg::SEQ_OFF |=> converter_on == 4'h0)
    else $error("converter on in shutdown");
  a_wake_wait : assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq == buck_seq_pkg::SEQ_OFF ##1 any_en |=> converter_on == 4'h0)
    else $error("converter started without wake delay");
  a_wake_skip : assert property (@(posedge clk_sys) disable iff (!rst_n)
    seq == buck_seq_pkg::SEQ_RUN && flt == buck_seq_pkg::FLT_NONE
      |=> converter_on == $past(en_s))
    else $error("enabled converter not started at once");
  a_therm_wait : assert property (@(posedge clk_sys) disable iff (!rst_n)
    flt == buck_seq_pkg::FLT_DOWN && by_therm ##1 flt == buck_seq_pkg::FLT_RESTART
      |-> calm_cnt == FW'(THERM_SAFE_CYC))
    else $error("thermal restart before safety delay");
endmodule : buck_sequencer

// [logic/pg_hold.sv]
`include "buck_seq_map.svh"

module pg_hold #(
  parameter int HOLD_CYC = `PG_HOLD_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic force_low,
  input  wire logic above_hi,
  input  wire logic below_lo,
  output logic      pg
);
  logic [$clog2(HOLD_CYC+1)-1:0] cnt;
  wire  hold_done = (cnt == '0);

  // Any drop restarts the hold window
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= $bits(cnt)'(HOLD_CYC);
      pg  <= 1'b0;
    end else if (force_low || (pg && below_lo)) begin
      cnt <= $bits(cnt)'(HOLD_CYC);
      pg  <= 1'b0;
    end else if (!pg) begin
      if (!hold_done) cnt <= cnt - 1'b1;
      pg <= hold_done && above_hi;
    end
  end

  a_hold_min : assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(pg) |-> !pg [*8])
    else $error("power good released before hold time");
  a_drop_low : assert property (@(posedge clk_sys) disable iff (!rst_n)
    force_low |=> !pg)
    else $error("power good not pulled low");
endmodule : pg_hold

// [logic/phase_pwm.sv]
`include "buck_seq_map.svh"

module phase_pwm #(
  parameter int PERIOD = `SW_PERIOD
) (
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  conv_ctrl_if.pwm    cc
);
  logic [$clog2(PERIOD)-1:0] phase;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (phase == $bits(phase)'(PERIOD - 1)) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  // Forced PWM: one minimum pulse per cycle, even at no load
  genvar g;
  generate
    for (g = 0; g < `NUM_CONV; g++) begin : g_ph
      localparam int OFFS = g * PERIOD / `NUM_CONV;
      logic pulse;
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pulse <= 1'b0;
        end else begin
          pulse <= cc.run[g] && (phase == $bits(phase)'(OFFS));
        end
      end
      assign cc.pwm_pulse[g] = pulse;
    end
  endgenerate

  a_phase_apart : assert property (@(posedge clk_sys) disable iff (!rst_n)
    $onehot0(cc.pwm_pulse))
    else $error("two high-side turn-ons coincide");
endmodule : phase_pwm

// [shared/buck_seq_map.svh]
`ifndef BUCK_SEQ_MAP_SVH
`define BUCK_SEQ_MAP_SVH

// ----------------------------------------
// Timing, in microseconds and clock counts
// ----------------------------------------
`define CLK_MHZ            50
`define WAKE_US            420
`define WAKE_CYC           (`WAKE_US * `CLK_MHZ)
`define PG_HOLD_US         50000
`define PG_HOLD_CYC        (`PG_HOLD_US * `CLK_MHZ)
`define QUAL_US            5000
`define QUAL_CYC           (`QUAL_US * `CLK_MHZ)
`define THERM_SAFE_US      2000000
`define THERM_SAFE_CYC     (`THERM_SAFE_US * `CLK_MHZ)
`define STEP_US            500
`define STEP_CYC           (`STEP_US * `CLK_MHZ)

// ----------------------------------------
// Switching period and phase layout
// ----------------------------------------
`define SW_PERIOD          16
`define SW_MIN_PULSE       1
`define NUM_CONV           4

// ----------------------------------------
// Level select codes for converter 3
// ----------------------------------------
`define OUT3_LOW_CODE      1'b0
`define OUT3_HIGH_CODE     1'b1

`endif

// [shared/buck_seq_pkg.sv]
package buck_seq_pkg;
  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_WAKE,
    SEQ_RUN
  } seq_state_e;

  typedef enum logic [1:0] {
    FLT_NONE,
    FLT_WARN,
    FLT_DOWN,
    FLT_RESTART
  } fault_state_e;

  typedef logic [3:0] conv_vec_t;
endpackage : buck_seq_pkg

// [shared/conv_ctrl_if.sv]
interface conv_ctrl_if;
  buck_seq_pkg::conv_vec_t run;
  buck_seq_pkg::conv_vec_t pwm_pulse;

  modport src (output run, input pwm_pulse);
  modport pwm (input run, output pwm_pulse);
endinterface : conv_ctrl_if

// [tb/quad_buck_sequencer_supervisor_tb.sv]
`include "buck_seq_map.svh"

module quad_buck_sequencer_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Shortened counts
  // ----------------------------------------
  localparam int WAKE  = 20;
  localparam int HOLD  = 50;
  localparam int QUAL  = 10;
  localparam int THERM = 100;
  localparam int STEP  = 8;

  logic       clk_sys;
  logic       rst_n;
  logic       lvl;
  logic       out3;
  logic [2:0] flt;
  logic [3:0] want, droop, en, fb_hi, fb_lo, on, sw, dis, pg;
  int         n_errors = 0;
  int         compares = 0;
  int         cyc      = 0;

  buck_sequencer #(.WAKE_CYC(WAKE), .HOLD_CYC(HOLD), .QUAL_CYC(QUAL),
                   .THERM_SAFE_CYC(THERM), .STEP_CYC(STEP)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .converter_enable(en), .feedback_hi(fb_hi),
    .feedback_lo(fb_lo), .out3_level_select(lvl), .thermal_trip(flt[2]),
    .input_low_lockout(flt[0]), .input_high_guard(flt[1]), .converter_on(on),
    .switch_pulse(sw), .discharge_on(dis), .power_good_out(pg), .out3_level(out3));

  sys_ctrl_model u_ctrl (
    .clk_sys(clk_sys), .want_en(want), .droop(droop), .converter_on(on),
    .converter_enable(en), .feedback_hi(fb_hi), .feedback_lo(fb_lo));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc <= cyc + 1;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk_bits(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_bits

  task automatic chk_range(input string what, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_range

  // Bounded wait; a miss shows up in the range or bit check that follows
  task automatic wait_hi(input logic [3:0] m, input bit use_pg, input int lim);
    int n;
    n = 0;
    while ((((use_pg ? pg : on) & m) !== m) && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_hi

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_wake(input string name);
    int t0;
    want = 4'h1;
    t0 = cyc;
    wait_hi(4'h1, 0, 4 * WAKE);
    chk_range("wake delay", WAKE, WAKE + 6, cyc - t0);
    chk_bits("discharge", 4'he, dis);
    $display("Test %s finished", name);
  endtask : test_wake

  task automatic test_second();
    int t0;
    want = 4'h3;
    t0 = cyc;
    wait_hi(4'h2, 0, 20);
    chk_range("second start", 1, 6, cyc - t0);
    want = 4'hf;
    wait_hi(4'hf, 0, 20);
    chk_bits("all running", 4'hf, on);
    $display("Test second start finished");
  endtask : test_second

  task automatic test_pg();
    int t0;
    wait_hi(4'hf, 1, 3 * HOLD);
    chk_bits("pg all up", 4'hf, pg);
    t0 = cyc;
    droop = 4'h4;
    repeat (5) @(negedge clk_sys);
    chk_bits("pg droop", 4'hb, pg);
    droop = 4'h0;
    wait_hi(4'hf, 1, 3 * HOLD);
    chk_range("pg hold", HOLD, HOLD + 10, cyc - t0);
    $display("Test power good finished");
  endtask : test_pg

  task automatic test_level();
    for (int v = 0; v < 2; v++) begin
      lvl = v[0];
      repeat (4) @(negedge clk_sys);
      chk_bits("out3 level", {3'h0, lvl}, {3'h0, out3});
    end
    $display("Test level select finished");
  endtask : test_level

  task automatic test_pwm();
    int         cnt [4];
    logic [3:0] ovl;
    cnt = '{default: 0};
    ovl = 4'h0;
    repeat (2 * `SW_PERIOD) begin
      @(negedge clk_sys);
      for (int i = 0; i < 4; i++) cnt[i] += sw[i];
      if ($countones(sw) > 1) ovl = 4'hf;
    end
    for (int i = 0; i < 4; i++) chk_range("pulses", 2, 2, cnt[i]);
    chk_bits("pulse overlap", 4'h0, ovl);
    $display("Test switching finished");
  endtask : test_pwm

  task automatic test_disable();
    want = 4'hd;
    repeat (4) @(negedge clk_sys);
    chk_bits("conv off", 4'hd, on);
    chk_bits("pg off", 4'hd, pg);
    chk_bits("discharge one", 4'h2, dis);
    want = 4'hf;
    wait_hi(4'hf, 0, 10);
    chk_bits("restart at once", 4'hf, on);
    $display("Test disable finished");
  endtask : test_disable

  task automatic fault_run(input string name, input int kind, input int dur, input bit slow);
    int t0;
    int tc;
    int t [4];
    wait_hi(4'hf, 1, 4 * HOLD);
    t0 = cyc;
    flt[kind] = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_bits("pg on fault", 4'h0, pg);
    chk_bits("lead time", 4'hf, on);
    repeat (dur - 4) @(negedge clk_sys);
    chk_bits("qualified stop", dur > QUAL ? 4'h0 : 4'hf, on);
    flt[kind] = 1'b0;
    tc = cyc;
    if (dur > QUAL) begin
      for (int i = 0; i < 4; i++) begin
        wait_hi(4'h1 << i, 0, THERM + 4 * STEP + 40);
        t[i] = cyc;
      end
      // Thermal restart must also sit out the safety delay
      chk_range("first restart", slow ? THERM : 0, (slow ? THERM : 0) + STEP + 10,
                t[0] - tc);
      for (int i = 1; i < 4; i++) begin
        chk_range("spacing", STEP - 1, STEP + 1, t[i] - t[i-1]);
      end
    end
    wait_hi(4'hf, 1, 4 * HOLD + THERM);
    chk_range("pg release", HOLD, 3 * HOLD + THERM + dur,
              cyc - t0);
    chk_bits("running after", 4'hf, on);
    $display("Test %s finished", name);
  endtask : fault_run

  task automatic test_shutdown();
    want = 4'h0;
    repeat (4) @(negedge clk_sys);
    chk_bits("all off", 4'h0, on);
    chk_bits("all discharge", 4'hf, dis);
    chk_bits("pg all low", 4'h0, pg);
    repeat (5) @(negedge clk_sys);
    test_wake("wake again");
  endtask : test_shutdown

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    want  = 4'h0;
    droop = 4'h0;
    flt   = 3'h0;
    lvl   = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk_bits("reset discharge", 4'hf, dis);
    chk_bits("reset pg", 4'h0, pg);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    test_wake("first wake");
    test_second();
    test_pg();
    test_level();
    test_pwm();
    test_disable();
    fault_run("undervolt short", 0, 6, 1'b0);
    fault_run("undervolt medium", 0, 30, 1'b0);
    fault_run("overvolt short", 1, 6, 1'b0);
    fault_run("overvolt medium", 1, 30, 1'b0);
    fault_run("thermal", 2, 30, 1'b1);
    test_shutdown();
    report_and_stop();
  end

  // Whole run needs roughly a thousand cycles; this is ample margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    $display("ERROR watchdog expected finish seen hang");
    report_and_stop();
  end
endmodule : quad_buck_sequencer_supervisor_tb

// [tb/sys_ctrl_model.sv]
module sys_ctrl_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] want_en,
  input  wire logic [3:0] droop,
  input  wire logic [3:0] converter_on,
  output logic      [3:0] converter_enable,
  output logic      [3:0] feedback_hi,
  output logic      [3:0] feedback_lo
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Controller enables and output ramp model
  // ----------------------------------------
  logic [3:0] ramp [0:3] = '{default: 4'h0};

  // Enables follow the bench directly, so no edge race on the falling edge
  assign converter_enable = want_en;

  // Soft start: output crosses the low threshold first, the high one later
  always @(posedge clk_sys) begin
    ramp[0] <= converter_on;
    ramp[1] <= ramp[0] & converter_on;
    ramp[2] <= ramp[1] & converter_on;
    ramp[3] <= ramp[2] & converter_on;
  end

  // Overload droop pulls both comparators low at once
  assign feedback_lo = ramp[1] & ~droop;
  assign feedback_hi = ramp[3] & ~droop;
endmodule : sys_ctrl_model
